/* scmd_interp.sv */
// Command block interpreter: create connection and dial commands
`timescale 1ns/1ps
module scmd_interp
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Host block write port and trigger
    input  wire logic                    hostWe,
    input  wire logic [scmd_pkg::ADDR_W-1:0] hostAddr,
    input  wire logic [scmd_pkg::WORD_W-1:0] hostData,
    input  wire logic                    hostGo,
    // Host block read port
    input  wire logic [scmd_pkg::ADDR_W-1:0] hostRdAddr,
    output logic      [scmd_pkg::WORD_W-1:0] hostRdData,
    // Command status
    output logic                         busy,
    output logic                         done,
    output logic      [scmd_pkg::WORD_W-1:0] errCode,
    // Connection settings
    output logic                         connUp,
    output logic      [1:0]              protoSel,
    output logic      [2:0]              portSel,
    output logic      [scmd_pkg::WORD_W-1:0] baudRate,
    output logic                         eightBits,
    output logic      [1:0]              parityMode,
    output logic                         twoStop,
    output logic      [1:0]              flowMode,
    output logic                         modemEn,
    output logic      [scmd_pkg::WORD_W-1:0] tableAddr,
    // Modem dial sequencer
    output logic                         dialStart,
    output logic                         modemResetFirst,
    output logic      [scmd_pkg::WORD_W-1:0] dialStrAddr,
    output logic                         busyDetect,
    output logic                         toneDetect,
    output logic                         stayCmdMode,
    input  wire logic                    modemDialDone,
    input  wire logic                    modemDialFail
);
    import scmd_pkg::*;

    scmd_blk_if blk();
    scmd_blk_mem uMem (
        .clk_sys (clk_sys),
        .bus     (blk.mem)
    );

    scmd_state_e state;
    logic [ADDR_W-1:0] idx;
    logic [WORD_W-1:0] cw [BLK_WORDS];
    logic [WORD_W-1:0] usedConn;
    logic [WORD_W-1:0] pendErr;
    logic [WORD_W-1:0] secLeft;
    logic [31:0]       tick;
    logic [WORD_W-1:0] readData;
    // One flag per connection number: a number is never reused
    localparam int CONN_SPAN = int'(CONN_MAX - CONN_MIN) + 1;
    logic [CONN_SPAN-1:0] usedMap;
    wire logic [WORD_W-1:0] connOfs = cw[W_CONN] - CONN_MIN;

    // Decode of captured block
    wire logic isCreate = (cw[W_CMD] == CMD_CREATE);
    wire logic isDial = (cw[W_CMD] == CMD_DIAL);
    wire logic connOk = (cw[W_CONN] >= CONN_MIN) && (cw[W_CONN] <= CONN_MAX);
    wire logic connFresh = !usedMap[connOfs[6:0]];
    wire logic protoOk = (cw[W_PROTO] == PROTO_PEER) ||
                         (cw[W_PROTO] == PROTO_GENERIC) ||
                         (cw[W_PROTO] == PROTO_TASK);
    wire logic portOk = (cw[W_PORT] >= PORT_MIN) && (cw[W_PORT] <= PORT_MAX);
    wire logic baudOk = (cw[W_BAUD] == BAUD_300) || (cw[W_BAUD] == BAUD_600) ||
                        (cw[W_BAUD] == BAUD_1200) ||
                        (cw[W_BAUD] == BAUD_2400) ||
                        (cw[W_BAUD] == BAUD_4800) ||
                        (cw[W_BAUD] == BAUD_9600) ||
                        (cw[W_BAUD] == BAUD_19200);
    wire logic fmtOk = ((cw[W_BITS] == BITS_7) || (cw[W_BITS] == BITS_8)) &&
                       (cw[W_PAR] <= PAR_MAX) &&
                       ((cw[W_STOP] == STOP_1) || (cw[W_STOP] == STOP_2));
    wire logic flowOk = (cw[W_FLOW] <= FLOW_MAX);
    // only the modem option bit may be set
    wire logic optOk = (cw[W_OPT] <= OPT_MODEM);
    // flag bits above the low bit must be zero
    wire logic flagOk = (cw[W_FLAG] <= ONE_BIT_MAX);
    wire logic dstrOk = (cw[W_DSTR] != ZERO_WORD);
    // busy, tone and done words take 0 or 1
    wire logic detOk = (cw[W_BUSY] <= ONE_BIT_MAX) &&
                       (cw[W_TONE] <= ONE_BIT_MAX) &&
                       (cw[W_DONE] <= ONE_BIT_MAX);
    logic [BLK_WORDS-1:0] rsvZero;
    genvar g;
    generate
        for (g = 0; g < BLK_WORDS; g++)
        begin : gRsv
            assign rsvZero[g] = (g < RSV_LO) || (cw[g] == ZERO_WORD);
        end
    endgenerate
    wire logic rsvOk = &rsvZero;
    // dial must name the live connection
    wire logic dialConnOk = connUp && (cw[W_CONN] == usedConn);

    // first failing check picks the code
    wire logic [WORD_W-1:0] createErr =
        !connOk    ? ERR_CONN  :
        !connFresh ? ERR_USED  :
        !protoOk   ? ERR_PROTO :
        !portOk    ? ERR_PORT  :
        !(baudOk && fmtOk && flowOk && optOk) ? ERR_LINE : ZERO_WORD;
    wire logic [WORD_W-1:0] dialErr =
        !connOk     ? ERR_CONN   :
        !dialConnOk ? ERR_NOCONN :
        !(flagOk && dstrOk && detOk && rsvOk) ? ERR_DIAL : ZERO_WORD;
    wire logic [WORD_W-1:0] checkErr =
        isCreate ? createErr : isDial ? dialErr : ERR_CMD;

    // Host owns the memory while idle; interpreter writes word zero back
    assign blk.we = (state == ST_WBACK) || ((state == ST_IDLE) && hostWe);
    assign blk.waddr = (state == ST_WBACK) ? W_ERR : hostAddr;
    assign blk.wdata = (state == ST_WBACK) ? pendErr : hostData;
    assign blk.raddr = (state == ST_LOAD) ? idx : hostRdAddr;
    assign readData = blk.rdata;
    wire logic secTick = (tick == TICK_MAX);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            idx <= '0;
            pendErr <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            errCode <= '0;
            connUp <= 1'b0;
            usedConn <= '0;
            usedMap <= '0;
            protoSel <= '0;
            portSel <= '0;
            baudRate <= '0;
            eightBits <= 1'b0;
            parityMode <= '0;
            twoStop <= 1'b0;
            flowMode <= '0;
            modemEn <= 1'b0;
            tableAddr <= '0;
            dialStart <= 1'b0;
            modemResetFirst <= 1'b0;
            dialStrAddr <= '0;
            busyDetect <= 1'b0;
            toneDetect <= 1'b0;
            stayCmdMode <= 1'b0;
            secLeft <= '0;
            tick <= '0;
            hostRdData <= '0;
        end
        else
        begin
            hostRdData <= readData;
            done <= 1'b0;
            dialStart <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (hostGo)
                    begin
                        busy <= 1'b1;
                        idx <= '0;
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    // Read data lags the address by one cycle
                    if (idx != W_ERR)
                        cw[idx - 4'h1] <= readData;
                    if (idx == 4'hF)
                        state <= ST_CHECK;
                    idx <= idx + 4'h1;
                    if (idx == 4'hF)
                        idx <= 4'hF;
                end
                ST_CHECK:
                begin
                    cw[4'hF] <= readData;
                    state <= ST_START;
                end
                ST_START:
                begin
                    pendErr <= checkErr;
                    if (checkErr != ZERO_WORD)
                        state <= ST_WBACK;
                    else if (isCreate)
                    begin
                        connUp <= 1'b1;
                        usedConn <= cw[W_CONN];
                        usedMap[connOfs[6:0]] <= 1'b1;
                        protoSel <= (cw[W_PROTO] == PROTO_PEER) ? 2'd0 :
                                    (cw[W_PROTO] == PROTO_GENERIC) ? 2'd1 :
                                    2'd2;
                        portSel <= cw[W_PORT][2:0];
                        baudRate <= cw[W_BAUD];
                        eightBits <= (cw[W_BITS] == BITS_8);
                        parityMode <= cw[W_PAR][1:0];
                        twoStop <= (cw[W_STOP] == STOP_2);
                        // modem handshake is left to the user
                        flowMode <= cw[W_FLOW][1:0];
                        modemEn <= cw[W_OPT][0];
                        tableAddr <= cw[W_TABLE];
                        state <= ST_WBACK;
                    end
                    else
                        state <= ST_DIAL;
                end
                ST_DIAL:
                begin
                    // launch the off-hook and dial series
                    dialStart <= 1'b1;
                    // low flag bit clear means reset first
                    modemResetFirst <= ~cw[W_FLAG][0];
                    dialStrAddr <= cw[W_DSTR];
                    busyDetect <= ~cw[W_BUSY][0];
                    toneDetect <= ~cw[W_TONE][0];
                    stayCmdMode <= cw[W_DONE][0];
                    secLeft <= cw[W_TMO];
                    tick <= '0;
                    state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    tick <= secTick ? '0 : tick + 32'd1;
                    if (secTick && secLeft != ZERO_WORD)
                        secLeft <= secLeft - 16'h0001;
                    if (modemDialFail)
                    begin
                        pendErr <= ERR_FAIL;
                        state <= ST_WBACK;
                    end
                    else if (modemDialDone)
                        state <= ST_WBACK;
                    // A zero timeout waits on the modem alone
                    else if (secTick && secLeft == 16'h0001)
                    begin
                        pendErr <= ERR_TIMEOUT;
                        state <= ST_WBACK;
                    end
                end
                ST_WBACK:
                begin
                    // error code lands in word zero
                    errCode <= pendErr;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule

/* scmd_pkg.sv */
// Constants and types for the serial command block interpreter
// Functional notes
// - Processing error writes code into word zero
// - Create code one, connection number in range
// - Word three picks protocol handler
// - Word four picks serial port one-four
// - Word five accepts seven listed baud rates
// - Data bits, parity, stop bits checked
// - Word nine selects flow control mode
// - Option bit enables modem, reads table
// - Dial code 0x0401 starts dial series
// - Command flag chooses modem reset first
// - Dial string address zero is invalid
// - Word five controls busy-tone detection
// - Word six controls dial-tone detection
// - Word seven picks completion modem mode
// - Word eight timeout, words 9-15 zero
// - Complete on modem done, error otherwise
package scmd_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int BLK_WORDS = 16;
    localparam logic [WORD_W-1:0] CMD_CREATE = 16'h0001;
    localparam logic [WORD_W-1:0] CMD_DIAL = 16'h0401;
    localparam logic [WORD_W-1:0] CONN_MIN = 16'h4B15;
    localparam logic [WORD_W-1:0] CONN_MAX = 16'h4B63;
    localparam logic [WORD_W-1:0] PROTO_PEER = 16'h0024;
    localparam logic [WORD_W-1:0] PROTO_GENERIC = 16'h0026;
    localparam logic [WORD_W-1:0] PROTO_TASK = 16'h0020;
    localparam logic [WORD_W-1:0] PORT_MIN = 16'h0001;
    localparam logic [WORD_W-1:0] PORT_MAX = 16'h0004;
    localparam logic [WORD_W-1:0] BAUD_300 = 16'h012C;
    localparam logic [WORD_W-1:0] BAUD_600 = 16'h0258;
    localparam logic [WORD_W-1:0] BAUD_1200 = 16'h04B0;
    localparam logic [WORD_W-1:0] BAUD_2400 = 16'h0960;
    localparam logic [WORD_W-1:0] BAUD_4800 = 16'h12C0;
    localparam logic [WORD_W-1:0] BAUD_9600 = 16'h2580;
    localparam logic [WORD_W-1:0] BAUD_19200 = 16'h4B00;
    localparam logic [WORD_W-1:0] BITS_7 = 16'h0007;
    localparam logic [WORD_W-1:0] BITS_8 = 16'h0008;
    localparam logic [WORD_W-1:0] PAR_MAX = 16'h0002;
    localparam logic [WORD_W-1:0] STOP_1 = 16'h0001;
    localparam logic [WORD_W-1:0] STOP_2 = 16'h0002;
    localparam logic [WORD_W-1:0] FLOW_MAX = 16'h0002;
    localparam logic [WORD_W-1:0] ONE_BIT_MAX = 16'h0001;
    localparam logic [WORD_W-1:0] OPT_MODEM = 16'h0001;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
    // Word offsets in a command block
    localparam logic [ADDR_W-1:0] W_ERR = 4'h0;
    localparam logic [ADDR_W-1:0] W_CMD = 4'h1;
    localparam logic [ADDR_W-1:0] W_CONN = 4'h2;
    localparam logic [ADDR_W-1:0] W_PROTO = 4'h3;
    localparam logic [ADDR_W-1:0] W_FLAG = 4'h3;
    localparam logic [ADDR_W-1:0] W_PORT = 4'h4;
    localparam logic [ADDR_W-1:0] W_DSTR = 4'h4;
    localparam logic [ADDR_W-1:0] W_BAUD = 4'h5;
    localparam logic [ADDR_W-1:0] W_BUSY = 4'h5;
    localparam logic [ADDR_W-1:0] W_BITS = 4'h6;
    localparam logic [ADDR_W-1:0] W_TONE = 4'h6;
    localparam logic [ADDR_W-1:0] W_PAR = 4'h7;
    localparam logic [ADDR_W-1:0] W_DONE = 4'h7;
    localparam logic [ADDR_W-1:0] W_STOP = 4'h8;
    localparam logic [ADDR_W-1:0] W_TMO = 4'h8;
    localparam logic [ADDR_W-1:0] W_FLOW = 4'h9;
    localparam logic [ADDR_W-1:0] W_OPT = 4'hA;
    localparam logic [ADDR_W-1:0] W_TABLE = 4'hB;
    localparam int RSV_LO = 9;
    // Error codes (plain values of our own)
    localparam logic [WORD_W-1:0] ERR_CMD = 16'h0101;
    localparam logic [WORD_W-1:0] ERR_CONN = 16'h0102;
    localparam logic [WORD_W-1:0] ERR_PROTO = 16'h0103;
    localparam logic [WORD_W-1:0] ERR_PORT = 16'h0104;
    localparam logic [WORD_W-1:0] ERR_LINE = 16'h0105;
    localparam logic [WORD_W-1:0] ERR_DIAL = 16'h0106;
    localparam logic [WORD_W-1:0] ERR_NOCONN = 16'h0107;
    localparam logic [WORD_W-1:0] ERR_FAIL = 16'h0108;
    localparam logic [WORD_W-1:0] ERR_TIMEOUT = 16'h0109;
    localparam logic [WORD_W-1:0] ERR_USED = 16'h010A;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MAX = CLK_HZ - 1;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_LOAD  = 7'b0000010,
        ST_CHECK = 7'b0000100,
        ST_START = 7'b0001000,
        ST_DIAL  = 7'b0010000,
        ST_WAIT  = 7'b0100000,
        ST_WBACK = 7'b1000000
    } scmd_state_e;
endpackage

/* scmd_blk_if.sv */
// Port bundle between the interpreter and its block memory
`timescale 1ns/1ps
interface scmd_blk_if;
    import scmd_pkg::*;
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [WORD_W-1:0] wdata;
    logic [ADDR_W-1:0] raddr;
    logic [WORD_W-1:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr,
                   input rdata);
    modport mem   (input we, input waddr, input wdata, input raddr,
                   output rdata);
endinterface

/* scmd_blk_mem.sv */
// Sixteen-word command block memory with registered read
`timescale 1ns/1ps
module scmd_blk_mem
    import scmd_pkg::*;
(
    // Clock
    input  wire logic  clk_sys,
    // Access
    scmd_blk_if.mem    bus
);
    logic [WORD_W-1:0] words [BLK_WORDS];

    always_ff @(posedge clk_sys)
    begin
        if (bus.we)
            words[bus.waddr] <= bus.wdata;
        bus.rdata <= words[bus.raddr];
    end
endmodule

/* scmd_interp_properties.sv */
// Port-level assertions for the command block interpreter
`timescale 1ns/1ps
module scmd_interp_chk
    import scmd_pkg::*;
(
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        rst,
    // Host side
    input wire logic                        hostWe,
    input wire logic [scmd_pkg::ADDR_W-1:0] hostAddr,
    input wire logic [scmd_pkg::WORD_W-1:0] hostData,
    input wire logic                        hostGo,
    input wire logic [scmd_pkg::ADDR_W-1:0] hostRdAddr,
    input wire logic [scmd_pkg::WORD_W-1:0] hostRdData,
    // Status and settings
    input wire logic                        busy,
    input wire logic                        done,
    input wire logic [scmd_pkg::WORD_W-1:0] errCode,
    input wire logic                        modemEn,
    input wire logic [scmd_pkg::WORD_W-1:0] tableAddr,
    // Dial side
    input wire logic                        dialStart,
    input wire logic                        modemResetFirst,
    input wire logic                        busyDetect,
    input wire logic                        toneDetect,
    input wire logic                        stayCmdMode,
    input wire logic                        modemDialFail
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadow of the block, with writes refused while busy
    logic [WORD_W-1:0] blk [BLK_WORDS];
    always_ff @(posedge clk_sys)
        if (hostWe && !busy)
            blk[hostAddr] <= hostData;
    wire isCre = blk[W_CMD] == CMD_CREATE;
    wire isDial = blk[W_CMD] == CMD_DIAL;
    wire badConn = blk[W_CONN] < CONN_MIN || blk[W_CONN] > CONN_MAX;
    wire badProto = blk[W_PROTO] != PROTO_PEER
        && blk[W_PROTO] != PROTO_GENERIC && blk[W_PROTO] != PROTO_TASK;
    wire badPort = blk[W_PORT] < PORT_MIN || blk[W_PORT] > PORT_MAX;
    wire errSet = errCode != ZERO_WORD;

    property p_bad_cmd; done && !isCre && !isDial |-> errSet; endproperty
    a_bad_cmd: assert property (p_bad_cmd)
        else $error("unknown command accepted");
    property p_bad_conn; done && isCre && badConn |-> errSet; endproperty
    a_bad_conn: assert property (p_bad_conn)
        else $error("connection number out of range accepted");
    property p_bad_proto; done && isCre && badProto |-> errSet; endproperty
    a_bad_proto: assert property (p_bad_proto)
        else $error("unknown protocol accepted");
    property p_bad_port; done && isCre && badPort |-> errSet; endproperty
    a_bad_port: assert property (p_bad_port)
        else $error("port out of range accepted");
    property p_dstr;
        done && isDial && blk[W_DSTR] == ZERO_WORD |-> errSet;
    endproperty
    a_dstr: assert property (p_dstr)
        else $error("zero dial string address accepted");
    property p_modem;
        done && isCre && !errSet |-> modemEn == blk[W_OPT][0]
            && tableAddr == blk[W_TABLE];
    endproperty
    a_modem: assert property (p_modem)
        else $error("modem enable differs from option bit");
    property p_flags;
        dialStart |-> isDial && modemResetFirst == !blk[W_FLAG][0]
            && busyDetect == (blk[W_BUSY] == ZERO_WORD)
            && toneDetect == (blk[W_TONE] == ZERO_WORD)
            && stayCmdMode == blk[W_DONE][0];
    endproperty
    a_flags: assert property (p_flags)
        else $error("dial options differ from block");
    property p_fail;
        busy && modemDialFail |-> ##[1:3] (done && errSet);
    endproperty
    a_fail: assert property (p_fail)
        else $error("modem failure not reported");
    property p_word0;
        done && hostRdAddr == W_ERR |-> ##2 hostRdData == $past(errCode, 2);
    endproperty
    a_word0: assert property (p_word0)
        else $error("word zero differs from error code");
    c_create: cover property (done && isCre && !errSet);
    c_dial: cover property (done && isDial && !errSet);
    c_fail: cover property (busy && modemDialFail);
endmodule

bind scmd_interp scmd_interp_chk scmd_interp_chk_i (.clk_sys(clk_sys),
    .rst(rst), .hostWe(hostWe), .hostAddr(hostAddr), .hostData(hostData),
    .hostGo(hostGo), .hostRdAddr(hostRdAddr), .hostRdData(hostRdData),
    .busy(busy), .done(done), .errCode(errCode), .modemEn(modemEn),
    .tableAddr(tableAddr),
    .dialStart(dialStart), .modemResetFirst(modemResetFirst),
    .busyDetect(busyDetect), .toneDetect(toneDetect),
    .stayCmdMode(stayCmdMode), .modemDialFail(modemDialFail));

/* scmd_modem_model.sv */
// Dial-up modem stand-in answering dial requests after a set delay
`timescale 1ns/1ps
module scmd_modem_model
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Dial request and scripted outcome
    input  wire logic       dialStart,
    input  wire logic       failNext,
    input  wire logic [7:0] dlyCyc,
    // Dial result lines
    output logic            modemDialDone,
    output logic            modemDialFail
);
    // Zero means no dial in progress
    logic [8:0] cnt;
    always_ff @(posedge clk_sys)
    begin
        modemDialDone <= 1'b0;
        modemDialFail <= 1'b0;
        if (rst)
            cnt <= 9'h000;
        else if (dialStart)
            cnt <= {1'b0, dlyCyc} + 9'h001;
        else if (cnt == 9'h001)
        begin
            cnt <= 9'h000;
            modemDialDone <= !failNext;
            modemDialFail <= failNext;
        end
        else if (cnt != 9'h000)
            cnt <= cnt - 9'h001;
    end
endmodule

/* scmd_interp_tb.sv */
// Self-checking testbench for the command block interpreter
`timescale 1ns/1ps
module scmd_interp_tb;
    import scmd_pkg::*;
    typedef struct packed {
        logic [WORD_W-1:0] err;
        logic [WORD_W-1:0] baud;
        logic [2:0]        port;
        logic [1:0]        proto;
        logic [6:0]        fmt;
    } scmd_exp_s;
    logic              clk_sys, rst, hostWe, hostGo, busy, done, dialStart;
    logic              modemDialDone, modemDialFail, failNext;
    logic [ADDR_W-1:0] hostAddr, hostRdAddr;
    logic [WORD_W-1:0] hostData, hostRdData, errCode, baudRate;
    logic [2:0]        portSel;
    logic [1:0]        protoSel, parityMode, flowMode;
    logic              eightBits, twoStop, modemEn;
    wire  [6:0]        fmtSeen = {eightBits, parityMode, twoStop, flowMode,
        modemEn};
    logic [7:0]        dlyCyc;
    logic [WORD_W-1:0] blk [BLK_WORDS];
    logic [WORD_W-1:0] bauds [7] = '{BAUD_300, BAUD_600, BAUD_1200,
        BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200};
    logic [WORD_W-1:0] protos [3] = '{PROTO_PEER, PROTO_GENERIC, PROTO_TASK};
    logic [WORD_W-1:0] conns [3] = '{CONN_MIN, 16'h4B30, CONN_MAX};
    logic [ADDR_W-1:0] cIdx [12] = '{W_CMD, W_CONN, W_CONN, W_PROTO, W_PORT,
        W_PORT, W_BAUD, W_BITS, W_PAR, W_STOP, W_FLOW, W_OPT};
    logic [WORD_W-1:0] cVal [12] = '{16'h0002, 16'h4B14, 16'h4B64, 16'h0025,
        16'h0000, 16'h0005, 16'h03E8, 16'h0009, 16'h0003, 16'h0003,
        16'h0003, 16'h0002};
    logic [WORD_W-1:0] cErr [12] = '{ERR_CMD, ERR_CONN, ERR_CONN, ERR_PROTO,
        ERR_PORT, ERR_PORT, ERR_LINE, ERR_LINE, ERR_LINE, ERR_LINE,
        ERR_LINE, ERR_LINE};
    logic [ADDR_W-1:0] dIdx [6] = '{W_CONN, W_DSTR, W_FLAG, W_BUSY, 4'h9,
        4'hF};
    logic [WORD_W-1:0] dVal [6] = '{16'h4B21, 16'h0000, 16'h0002, 16'h0002,
        16'h0001, 16'h0001};
    logic [WORD_W-1:0] dErr [6] = '{ERR_NOCONN, ERR_DIAL, ERR_DIAL,
        ERR_DIAL, ERR_DIAL, ERR_DIAL};
    scmd_exp_s         expQ [$];
    scmd_exp_s         cur, e;
    int                seed = 32'h1CFBE7AA;
    int                nErrors, checksDone, cycles;

    scmd_interp scmd_interp_i (.clk_sys(clk_sys), .rst(rst),
        .hostWe(hostWe), .hostAddr(hostAddr), .hostData(hostData),
        .hostGo(hostGo), .hostRdAddr(hostRdAddr), .hostRdData(hostRdData),
        .busy(busy), .done(done), .errCode(errCode), .connUp(),
        .protoSel(protoSel), .portSel(portSel), .baudRate(baudRate),
        .eightBits(eightBits), .parityMode(parityMode), .twoStop(twoStop),
        .flowMode(flowMode), .modemEn(modemEn),
        .tableAddr(), .dialStart(dialStart), .modemResetFirst(),
        .dialStrAddr(), .busyDetect(), .toneDetect(), .stayCmdMode(),
        .modemDialDone(modemDialDone), .modemDialFail(modemDialFail));
    scmd_modem_model scmd_modem_model_i (.clk_sys(clk_sys), .rst(rst),
        .dialStart(dialStart), .failNext(failNext), .dlyCyc(dlyCyc),
        .modemDialDone(modemDialDone), .modemDialFail(modemDialFail));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cmp16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checksDone++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic endOfTest;
        if (nErrors == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // word zero cleared in every fresh block
    task automatic newCreate(input logic [15:0] c, input logic [15:0] pr);
        int r;
        r = $random(seed);
        blk = '{default: ZERO_WORD};
        blk[W_CMD] = CMD_CREATE;
        blk[W_CONN] = c;
        blk[W_PROTO] = pr;
        blk[W_PORT] = {14'h0000, r[1:0]} + 16'h0001;
        blk[W_BAUD] = bauds[r[10:8] % 3'h7];
        blk[W_BITS] = r[2] ? BITS_8 : BITS_7;
        blk[W_PAR] = (r[4:3] == 2'h3) ? PAR_MAX : {14'h0000, r[4:3]};
        blk[W_STOP] = r[5] ? STOP_2 : STOP_1;
        blk[W_FLOW] = (r[7:6] == 2'h3) ? FLOW_MAX : {14'h0000, r[7:6]};
        blk[W_OPT] = {15'h0000, r[11]};
        blk[W_TABLE] = 16'h03E8;
        if (pr != PROTO_GENERIC)
        begin
            blk[W_BITS] = BITS_7;
            blk[W_PAR] = 16'h0001;
            blk[W_STOP] = STOP_1;
        end
    endtask

    // dial block names connection c, live or not
    task automatic newDial(input logic [15:0] c);
        int r;
        r = $random(seed);
        blk = '{default: ZERO_WORD};
        blk[W_CMD] = CMD_DIAL;
        blk[W_CONN] = c;
        blk[W_FLAG] = {15'h0000, r[0]};
        blk[W_DSTR] = 16'h03F8;
        blk[W_BUSY] = {15'h0000, r[1]};
        blk[W_TONE] = {15'h0000, r[2]};
        blk[W_DONE] = {15'h0000, r[3]};
        dlyCyc <= r[15:8];
    endtask

    // Writes the block, starts it, notes the outcome, reads word zero back
    task automatic issue(input logic [15:0] err);
        int w;
        for (int i = 0; i < BLK_WORDS; i++)
        begin
            @(posedge clk_sys);
            hostWe <= 1'b1;
            hostAddr <= i[3:0];
            hostData <= blk[i];
        end
        @(posedge clk_sys);
        hostWe <= 1'b0;
        hostGo <= 1'b1;
        if (err === ZERO_WORD && blk[W_CMD] === CMD_CREATE)
        begin
            cur.baud = blk[W_BAUD];
            cur.port = blk[W_PORT][2:0];
            cur.proto = (blk[W_PROTO] == PROTO_PEER) ? 2'h0
                : (blk[W_PROTO] == PROTO_GENERIC) ? 2'h1 : 2'h2;
            cur.fmt = {blk[W_BITS] == BITS_8, blk[W_PAR][1:0],
                blk[W_STOP] == STOP_2, blk[W_FLOW][1:0], blk[W_OPT][0]};
        end
        cur.err = err;
        expQ.push_back(cur);
        @(posedge clk_sys);
        hostGo <= 1'b0;
        for (w = 0; w < 600 && done !== 1'b1; w++)
            @(posedge clk_sys);
        if (w == 600)
            nErrors++;
        repeat (3) @(posedge clk_sys);
        cmp16("word0", err, hostRdData);
    endtask

    // Result watcher: each done retires the oldest note
    always @(posedge clk_sys)
        if (done === 1'b1)
        begin
            e = expQ.pop_front();
            cmp16("errCode", e.err, errCode);
            cmp16("baudRate", e.baud, baudRate);
            cmp16("portSel", {13'h0000, e.port}, {13'h0000, portSel});
            cmp16("protoSel", {14'h0000, e.proto}, {14'h0000, protoSel});
            cmp16("format", {9'h000, e.fmt}, {9'h000, fmtSeen});
        end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles > 6000)
        begin
            nErrors++;
            endOfTest();
        end
    end

    initial
    begin
        {rst, hostWe, hostGo, failNext} = 4'h8;
        {hostAddr, hostRdAddr, hostData, dlyCyc} = '0;
        cur = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        newDial(CONN_MIN);
        issue(ERR_NOCONN);
        // three creates stand without a dial block
        for (int p = 0; p < 3; p++)
        begin
            newCreate(conns[p], protos[p]);
            issue(ZERO_WORD);
        end
        newCreate(CONN_MIN, PROTO_TASK);
        issue(ERR_USED);
        for (int k = 0; k < 12; k++)
        begin
            newCreate(16'h4B40 + k[15:0], PROTO_GENERIC);
            blk[cIdx[k]] = cVal[k];
            issue(cErr[k]);
        end
        newCreate(16'h4B20, PROTO_PEER);
        issue(ZERO_WORD);
        for (int k = 0; k < 4; k++)
        begin
            newDial(16'h4B20);
            failNext <= k[0];
            issue(k[0] ? ERR_FAIL : ZERO_WORD);
        end
        for (int k = 0; k < 6; k++)
        begin
            newDial(16'h4B20);
            blk[dIdx[k]] = dVal[k];
            issue(dErr[k]);
        end
        endOfTest();
    end
endmodule
